// ===== logic/blepc_pkg.sv
// Package for the backlight enable and PWM-input control block.
// Assumes a single 20 MHz clock; the bench checker and test import it too.
package blepc_pkg;

  // Code widths
  localparam int BLEPC_CODE_W = 11;
  localparam int BLEPC_NSTR = 3;

  // Clock rate
  localparam int BLEPC_CLK_HZ = 20_000_000;
  localparam int BLEPC_CLK_NS = 50;

  // Reset defaults of the stored settings
  localparam logic BLEPC_CHIP_EN_RST = 1'h1;
  localparam logic BLEPC_PWM_EN_RST = 1'h1;
  localparam logic BLEPC_MAP_EXP_RST = 1'h0;
  localparam logic [2:0] BLEPC_STR_EN_RST = 3'h7;
  localparam logic [1:0] BLEPC_MODE_RST = 2'h1;
  localparam logic [1:0] BLEPC_FILT_RST = 2'h0;
  localparam logic [1:0] BLEPC_RATE_RST = 2'h3;
  localparam logic [1:0] BLEPC_HYST_RST = 2'h0;
  localparam logic [10:0] BLEPC_BRT_RST = 11'h000;

  // Brightness source modes
  localparam logic [1:0] BLEPC_MODE_I2C = 2'h0;
  localparam logic [1:0] BLEPC_MODE_PWM = 2'h1;

  // Glitch filter widths in ns (setting 01 taken as 100 ns)
  localparam int BLEPC_FILT0_NS = 15;
  localparam int BLEPC_FILT1_NS = 100;
  localparam int BLEPC_FILT2_NS = 150;
  localparam int BLEPC_FILT3_NS = 200;
  localparam int BLEPC_FILT_W = 3;
  // Least times round up to whole cycles, never below one
  localparam int BLEPC_FILT0_CYC = (BLEPC_FILT0_NS + BLEPC_CLK_NS - 1) / BLEPC_CLK_NS;
  localparam int BLEPC_FILT1_CYC = (BLEPC_FILT1_NS + BLEPC_CLK_NS - 1) / BLEPC_CLK_NS;
  localparam int BLEPC_FILT2_CYC = (BLEPC_FILT2_NS + BLEPC_CLK_NS - 1) / BLEPC_CLK_NS;
  localparam int BLEPC_FILT3_CYC = (BLEPC_FILT3_NS + BLEPC_CLK_NS - 1) / BLEPC_CLK_NS;

  // Sample dividers from the 20 MHz clock: 24 MHz not reachable, so the fastest
  // rate samples every clock; 4 MHz -> 5, 800 kHz -> 25; setting 01 taken as 1 MHz
  localparam int BLEPC_DIV_W = 5;
  localparam int BLEPC_RATE0_HZ = 800_000;
  localparam int BLEPC_RATE1_HZ = 1_000_000;
  localparam int BLEPC_RATE2_HZ = 4_000_000;
  localparam int BLEPC_DIV0 = BLEPC_CLK_HZ / BLEPC_RATE0_HZ;
  localparam int BLEPC_DIV1 = BLEPC_CLK_HZ / BLEPC_RATE1_HZ;
  localparam int BLEPC_DIV2 = BLEPC_CLK_HZ / BLEPC_RATE2_HZ;
  localparam int BLEPC_DIV3 = 1;

  // Shutdown timeout, counted in samples so it scales inversely with rate:
  // 800 kHz * 25 ms = 20000 samples, 20 MHz fastest rate * 1 ms = 20000 samples
  localparam int BLEPC_TMO_US = 25_000;
  localparam int BLEPC_TMO_SAMPLES = BLEPC_RATE0_HZ / 1000 * BLEPC_TMO_US / 1000;
  localparam int BLEPC_PER_W = 16;

  // Start-up delay after the enable pin rises
  localparam int BLEPC_START_US = 3_500;
  localparam int BLEPC_START_CYC = BLEPC_START_US * (BLEPC_CLK_HZ / 1_000_000);

  // Settings written by the host, carried together
  typedef struct packed {
    logic chip_en;
    logic [2:0] str_en;
    logic pwm_en;
    logic map_exp;
    logic [1:0] mode;
    logic [1:0] filt;
    logic [1:0] rate;
    logic [1:0] hyst;
    logic [10:0] brt;
  } blepc_cfg_t;

  localparam blepc_cfg_t BLEPC_CFG_RST = '{
    chip_en: BLEPC_CHIP_EN_RST, str_en: BLEPC_STR_EN_RST, pwm_en: BLEPC_PWM_EN_RST,
    map_exp: BLEPC_MAP_EXP_RST, mode: BLEPC_MODE_RST, filt: BLEPC_FILT_RST,
    rate: BLEPC_RATE_RST, hyst: BLEPC_HYST_RST, brt: BLEPC_BRT_RST};

endpackage

// ===== logic/blepc_sync.sv
// Three-stage synchroniser with agreement check for one asynchronous pin.
// Assumes the pin is unrelated to clk_i; reset value is a constant.
`timescale 1ns/1ns
module blepc_sync
  import blepc_pkg::*;
#(
  parameter logic RST_VAL = 1'h0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Pin and clean level
  input wire logic pin_i,
  output logic level_o
);

  logic [2:0] stage_reg; // Stage 0 is read only by stage 1
  logic level_reg; // Accepted level

  // Shift chain; the level moves only when stages 1 and 2 agree
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      stage_reg <= {3{RST_VAL}};
      level_reg <= RST_VAL;
    end else begin
      stage_reg <= {stage_reg[1:0], pin_i};
      if (stage_reg[1] == stage_reg[2]) begin
        level_reg <= stage_reg[2];
      end
    end
  end

  assign level_o = level_reg;

endmodule

// ===== logic/blepc_pwm_meas.sv
// Sampled PWM duty measurement: glitch filter, period and high counters,
// and conversion of the duty cycle to an 11-bit code.
// Assumes a synchronised PWM level and a one-cycle sample strobe.
`timescale 1ns/1ns
module blepc_pwm_meas
  import blepc_pkg::*;
#(
  parameter int CODE_W = BLEPC_CODE_W,
  parameter int PER_W = BLEPC_PER_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic run_i,
  input wire logic sample_i,
  input wire logic [BLEPC_FILT_W-1:0] filt_cyc_i,
  input wire logic [1:0] hyst_i,
  input wire logic pwm_i,
  // Result
  output logic [CODE_W-1:0] code_o,
  output logic high_o,
  output logic timeout_o
);

  initial begin
    if (CODE_W < 1 || PER_W < CODE_W) $error("blepc_pwm_meas: bad widths");
  end

  logic filt_reg; // Filtered PWM level
  logic [BLEPC_FILT_W-1:0] stable_reg; // Cycles the raw level differs
  logic [PER_W-1:0] per_reg; // Samples in the running period
  logic [PER_W-1:0] hi_reg; // High samples in the running period
  logic [PER_W-1:0] idle_reg; // Samples since the last edge
  logic [CODE_W-1:0] code_reg;
  logic timeout_reg;
  logic rise_pend_reg; // Rising edge seen between sample strobes
  logic fall_pend_reg; // Falling edge seen between sample strobes

  wire rise = filt_reg == 1'h0 && pwm_i == 1'h1 && stable_reg >= filt_cyc_i;
  wire fall = filt_reg == 1'h1 && pwm_i == 1'h0 && stable_reg >= filt_cyc_i;
  wire edge_take = rise || fall;
  // Edges taken by the filter off a strobe are kept until the next strobe
  wire rise_seen = rise || rise_pend_reg;
  wire fall_seen = fall || fall_pend_reg;
  wire sat = &per_reg;
  // Duty = high / period scaled to CODE_W bits
  wire [PER_W+CODE_W-1:0] scaled = {hi_reg, {CODE_W{1'b0}}} - {{CODE_W{1'b0}}, hi_reg};
  wire [PER_W+CODE_W-1:0] quot = (per_reg == '0) ? '0 : scaled / {{CODE_W{1'b0}}, per_reg};
  wire [CODE_W-1:0] new_code = quot[CODE_W-1:0];
  // Hysteresis: ignore changes of at most 2^hyst - 1 codes, unless the new code is zero
  wire [CODE_W-1:0] diff = (new_code > code_reg) ? new_code - code_reg : code_reg - new_code;
  wire [CODE_W-1:0] hyst_lim = CODE_W'((1 << hyst_i) - 1);
  wire take_code = diff > hyst_lim || new_code == '0;

  // Glitch filter: a change is accepted after filt_cyc_i stable cycles
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !run_i) begin
      filt_reg <= 1'h0;
      stable_reg <= '0;
    end else if (pwm_i == filt_reg || edge_take) begin
      filt_reg <= edge_take ? pwm_i : filt_reg;
      stable_reg <= '0;
    end else begin
      stable_reg <= stable_reg + BLEPC_FILT_W'(1);
    end
  end

  // Edge memory for slow sample rates; the strobe consumes it
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !run_i || sample_i) begin
      rise_pend_reg <= 1'h0;
      fall_pend_reg <= 1'h0;
    end else begin
      rise_pend_reg <= rise_pend_reg || rise;
      fall_pend_reg <= fall_pend_reg || fall;
    end
  end

  // Period measurement on the sample strobe, refreshed at each rising edge
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !run_i) begin
      per_reg <= '0;
      hi_reg <= '0;
      idle_reg <= '0;
      code_reg <= '0;
      timeout_reg <= 1'h0;
    end else if (sample_i) begin
      if (rise_seen) begin
        if (take_code) begin
          code_reg <= new_code;
        end
        per_reg <= PER_W'(1);
        // Filtered level lags one cycle, so the high count starts from zero
        hi_reg <= '0;
        idle_reg <= '0;
        timeout_reg <= 1'h0;
      end else begin
        per_reg <= sat ? per_reg : per_reg + PER_W'(1);
        hi_reg <= (filt_reg && !sat) ? hi_reg + PER_W'(1) : hi_reg;
        idle_reg <= fall_seen ? '0 : (idle_reg == '1 ? idle_reg : idle_reg + PER_W'(1));
        // Static input for a whole timeout: 100 % or 0 % duty
        if (idle_reg >= PER_W'(BLEPC_TMO_SAMPLES)) begin
          timeout_reg <= 1'h1;
          code_reg <= filt_reg ? '1 : '0;
        end
      end
    end
  end

  assign code_o = code_reg;
  assign high_o = filt_reg;
  assign timeout_o = timeout_reg;

endmodule

// ===== logic/blepc_top.sv
// Enable, start-up and PWM-input control of a three-string backlight driver.
// Assumes a host-side bus decoder hands in complete register writes and a
// PWM source drives pwm_i; both pins are asynchronous to clk_i.
// Function
// - Enable pin low: disabled, defaults, ignore bus
// - Enable pin high: enabled, writes accepted
// - Each of three sinks separately enabled
// - All three sinks enabled after reset
// - Defaults: chip enable, PWM enabled, linear mapping
// - Default start: watch PWM, convert duty to code
// - Code from I2C, PWM, or their product
// - Full 11-bit PWM resolution at fastest rate
// - Pulse filter sets least accepted pulse width
// - PWM timeout scales inversely with sample rate
// - No strings or zero code: standby, no current
// - Linear: current proportional to code, zero off
`timescale 1ns/1ns
module blepc_top
  import blepc_pkg::*;
#(
  parameter int CODE_W = BLEPC_CODE_W,
  parameter int NSTR = BLEPC_NSTR,
  parameter int START_CYC = BLEPC_START_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Device pins
  input wire logic hardware_enable_pin_i,
  input wire logic pwm_i,
  // Register writes from the bus decoder
  input wire logic wr_i,
  input wire blepc_cfg_t wr_cfg_i,
  // Status and settings readback
  output blepc_cfg_t cfg_o,
  output logic enabled_o,
  output logic standby_o,
  output logic active_o,
  output logic pwm_timeout_o,
  // Drive to the current sinks
  output logic [NSTR-1:0] sink_en_o,
  output logic [CODE_W-1:0] led_code_o,
  output logic map_exp_o
);

  // Refuse shapes the logic cannot serve
  initial begin
    if (CODE_W != BLEPC_CODE_W) $error("blepc_top: code width must be 11");
    if (NSTR != BLEPC_NSTR) $error("blepc_top: three sinks only");
    if (START_CYC < 1) $error("blepc_top: start delay must be positive");
  end

  typedef enum logic [1:0] {
    BLEPC_OFF,
    BLEPC_START,
    BLEPC_STBY,
    BLEPC_ON
  } blepc_state_t;

  logic en_sync; // Synchronised enable pin
  logic pwm_sync; // Synchronised PWM pin
  blepc_cfg_t cfg_reg; // Stored settings
  blepc_state_t state_reg;
  blepc_state_t state_next;
  logic [$clog2(START_CYC+1)-1:0] start_reg; // Start-up delay count
  logic [BLEPC_DIV_W-1:0] div_reg; // Sample divider
  logic [NSTR-1:0] sink_reg;
  logic [CODE_W-1:0] code_reg;
  logic map_reg;
  logic [CODE_W-1:0] pwm_code;
  logic pwm_timeout;

  // Both pins pass four flops before any use
  blepc_sync #(.RST_VAL(1'h0)) u_sync_en (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(hardware_enable_pin_i),
    .level_o(en_sync)
  );

  blepc_sync #(.RST_VAL(1'h0)) u_sync_pwm (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(pwm_i),
    .level_o(pwm_sync)
  );

  // Settings hold their defaults while the pin is low; writes then dropped
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !en_sync) begin
      cfg_reg <= BLEPC_CFG_RST;
    end else if (wr_i) begin
      cfg_reg <= wr_cfg_i;
    end
  end

  // Sample rate select; the fastest setting samples every clock
  wire [BLEPC_DIV_W-1:0] div_max =
    (cfg_reg.rate == 2'h0) ? BLEPC_DIV_W'(BLEPC_DIV0 - 1) :
    (cfg_reg.rate == 2'h1) ? BLEPC_DIV_W'(BLEPC_DIV1 - 1) :
    (cfg_reg.rate == 2'h2) ? BLEPC_DIV_W'(BLEPC_DIV2 - 1) :
    BLEPC_DIV_W'(BLEPC_DIV3 - 1);
  wire sample = (div_reg == div_max);

  // Glitch width select for the pulse filter
  wire [BLEPC_FILT_W-1:0] filt_cyc =
    (cfg_reg.filt == 2'h0) ? BLEPC_FILT_W'(BLEPC_FILT0_CYC - 1) :
    (cfg_reg.filt == 2'h1) ? BLEPC_FILT_W'(BLEPC_FILT1_CYC - 1) :
    (cfg_reg.filt == 2'h2) ? BLEPC_FILT_W'(BLEPC_FILT2_CYC - 1) :
    BLEPC_FILT_W'(BLEPC_FILT3_CYC - 1);

  // Sample strobe divider; runs only while enabled to save power
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !en_sync || sample) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + BLEPC_DIV_W'(1);
    end
  end

  wire meas_run = en_sync && cfg_reg.chip_en && cfg_reg.pwm_en;

  // Duty measurement of the PWM input
  blepc_pwm_meas #(.CODE_W(CODE_W), .PER_W(BLEPC_PER_W)) u_meas (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .run_i(meas_run),
    .sample_i(sample),
    .filt_cyc_i(filt_cyc),
    .hyst_i(cfg_reg.hyst),
    .pwm_i(pwm_sync),
    .code_o(pwm_code),
    .high_o(),
    .timeout_o(pwm_timeout)
  );

  // Source selection: I2C code, PWM code, or their 11-bit product
  wire [2*CODE_W-1:0] prod = cfg_reg.brt * pwm_code;
  wire [CODE_W-1:0] pwm_eff = cfg_reg.pwm_en ? pwm_code : '0;
  wire [CODE_W-1:0] prod_eff = cfg_reg.pwm_en ? prod[2*CODE_W-1:CODE_W] : '0;
  wire [CODE_W-1:0] code_sel =
    (cfg_reg.mode == BLEPC_MODE_I2C) ? cfg_reg.brt :
    (cfg_reg.mode == BLEPC_MODE_PWM) ? pwm_eff : prod_eff;

  // Standby when no string or zero code
  wire want_on = cfg_reg.chip_en && (|cfg_reg.str_en) && (code_sel != '0);
  wire start_done = (start_reg == '0);

  // Power state: off, start-up wait, standby, on
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      BLEPC_OFF: begin
        if (en_sync) begin
          state_next = BLEPC_START;
        end
      end
      BLEPC_START: begin
        // Delay models the regulator start before current may flow
        if (start_done) begin
          state_next = BLEPC_STBY;
        end
      end
      BLEPC_STBY: begin
        if (want_on) begin
          state_next = BLEPC_ON;
        end
      end
      BLEPC_ON: begin
        if (!want_on) begin
          state_next = BLEPC_STBY;
        end
      end
      default: begin
        state_next = BLEPC_OFF;
      end
    endcase
    if (!en_sync) begin
      state_next = BLEPC_OFF;
    end
  end

  // State and start-up counter
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg <= BLEPC_OFF;
      start_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (state_reg == BLEPC_OFF) begin
        start_reg <= $bits(start_reg)'(START_CYC - 1);
      end else if (!start_done) begin
        start_reg <= start_reg - $bits(start_reg)'(1);
      end
    end
  end

  // Sink drive registers; zero code means zero current
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || state_next != BLEPC_ON) begin
      sink_reg <= '0;
      code_reg <= '0;
      map_reg <= BLEPC_MAP_EXP_RST;
    end else begin
      sink_reg <= cfg_reg.str_en;
      code_reg <= code_sel;
      map_reg <= cfg_reg.map_exp;
    end
  end

  assign cfg_o = cfg_reg;
  assign enabled_o = (state_reg != BLEPC_OFF);
  assign standby_o = (state_reg == BLEPC_STBY) || (state_reg == BLEPC_START);
  assign active_o = (state_reg == BLEPC_ON);
  assign pwm_timeout_o = pwm_timeout;
  assign sink_en_o = sink_reg;
  assign led_code_o = code_reg;
  assign map_exp_o = map_reg;

endmodule

// ===== bench/blepc_top_assertions.sv
// Port checker for the backlight enable and PWM control block.
// Sees only blepc_top ports; bound into every instance below.
`timescale 1ns/1ns
module blepc_top_assertions
  import blepc_pkg::*;
#(
  parameter int CODE_W = BLEPC_CODE_W,
  parameter int NSTR = BLEPC_NSTR
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Inputs
  input wire logic hardware_enable_pin_i,
  input wire logic pwm_i,
  input wire logic wr_i,
  input wire blepc_cfg_t wr_cfg_i,
  // Outputs
  input wire blepc_cfg_t cfg_o,
  input wire logic enabled_o,
  input wire logic standby_o,
  input wire logic active_o,
  input wire logic pwm_timeout_o,
  input wire logic [NSTR-1:0] sink_en_o,
  input wire logic [CODE_W-1:0] led_code_o,
  input wire logic map_exp_o
);
  // One domain, so clock and reset are stated once
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Eight low cycles outlast the synchroniser
  a_pin_low_dflt: assert property (
    (!hardware_enable_pin_i)[*8] |-> cfg_o == BLEPC_CFG_RST && !enabled_o)
    else $error("settings kept while pin low");
  a_write_taken: assert property (
    hardware_enable_pin_i[*8] ##0 (wr_i && enabled_o) |=> cfg_o == $past(wr_cfg_i))
    else $error("write not stored");
  a_write_dropped: assert property (
    (!hardware_enable_pin_i)[*8] ##0 wr_i |=> $stable(cfg_o))
    else $error("write stored while pin low");
  // Drive registers clear on the same edge that leaves the on state
  a_idle_zero: assert property (
    !active_o && !$past(active_o) |-> sink_en_o == '0 && led_code_o == '0)
    else $error("drive while not on");
  a_no_string: assert property (
    (cfg_o.str_en == 3'h0)[*3] |-> !active_o)
    else $error("on with no string");
  a_state_decode: assert property (
    $onehot0({standby_o, active_o}) && enabled_o == (standby_o | active_o))
    else $error("state flags disagree");
  a_start_wait: assert property (
    $rose(enabled_o) |-> (standby_o && !active_o)[*8])
    else $error("no start-up wait");
  a_timeout_full: assert property (
    (pwm_timeout_o && active_o && cfg_o.mode == BLEPC_MODE_PWM && $stable(cfg_o))[*2]
    |-> led_code_o == 11'h7FF)
    else $error("static high not full code");
  a_i2c_code: assert property (
    (active_o && cfg_o.mode == BLEPC_MODE_I2C && $stable(cfg_o))[*2]
    |-> led_code_o == cfg_o.brt)
    else $error("code not brightness");

  // Main scenarios reached
  c_pwm_on: cover property (active_o && cfg_o.mode == BLEPC_MODE_PWM);
  c_timeout_off: cover property (pwm_timeout_o && enabled_o && !active_o);
  c_pin_drop: cover property ($fell(enabled_o));
endmodule

bind blepc_top blepc_top_assertions #(.CODE_W(CODE_W), .NSTR(NSTR)) u_chk (
  .clk_i, .rst_n_i, .hardware_enable_pin_i, .pwm_i, .wr_i, .wr_cfg_i, .cfg_o,
  .enabled_o, .standby_o, .active_o, .pwm_timeout_o, .sink_en_o, .led_code_o, .map_exp_o);

// ===== bench/blepc_pwm_src.sv
// PWM source model standing at the far side of pwm_i.
// Assumes the bench clock; shape given in whole clock cycles.
`timescale 1ns/1ns
module blepc_pwm_src (
  // Clock
  input wire logic clk_i,
  // Period and high time; period 0 gives a static level
  input wire logic [15:0] per_i,
  input wire logic [15:0] hi_i,
  // Pin
  output logic pwm_o
);
  logic [15:0] cnt = 16'h0000; // Position in the period
  initial pwm_o = 1'h0;
  // Edges land just after the clock, as from an unrelated source
  always @(posedge clk_i) begin
    cnt <= (per_i == 16'h0000 || cnt >= per_i - 16'h0001) ? 16'h0000 : cnt + 16'h0001;
    pwm_o <= #2 (per_i == 16'h0000) ? (hi_i != 16'h0000) : (cnt < hi_i);
  end
endmodule

// ===== bench/blepc_top_test.sv
// Self-checking bench for the backlight enable and PWM control block.
// Drives pins and whole-settings writes; blepc_pwm_src drives pwm_i.
`timescale 1ns/1ns
module blepc_top_test;
  import blepc_pkg::*;
  localparam int START = 20; // Short start-up wait keeps the run brief
  localparam int LIMIT = 60000; // Two PWM timeouts plus margin
  // Design pins
  logic clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic hardware_enable_pin_i = 1'h0;
  logic pwm_i;
  logic wr_i = 1'h0;
  blepc_cfg_t wr_cfg_i = BLEPC_CFG_RST;
  blepc_cfg_t cfg_o;
  logic enabled_o, standby_o, active_o, pwm_timeout_o, map_exp_o;
  logic [2:0] sink_en_o;
  logic [10:0] led_code_o;
  // PWM shape in cycles
  logic [15:0] per = 16'h0000;
  logic [15:0] hi = 16'h0000;
  // Bench state
  blepc_cfg_t c;
  logic [15:0] lf = 16'h513A; // Random state, starts at 20794
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  int k;

  blepc_top #(.START_CYC(START)) dut (
    .clk_i, .rst_n_i, .hardware_enable_pin_i, .pwm_i, .wr_i, .wr_cfg_i, .cfg_o,
    .enabled_o, .standby_o, .active_o, .pwm_timeout_o, .sink_en_o, .led_code_o, .map_exp_o);
  blepc_pwm_src src (.clk_i, .per_i(per), .hi_i(hi), .pwm_o(pwm_i));

  // Clock, and a ceiling in case the design hangs
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_errors++;
      $display("CHECK FAILED %0t run too long", $time);
      final_report();
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Expected code: brightness, PWM code, or top 11 bits of the product
  function automatic int model(input blepc_cfg_t s, input int pc);
    if (s.mode == BLEPC_MODE_I2C) return s.brt;
    if (s.mode == BLEPC_MODE_PWM) return pc;
    return (s.brt * pc) >> 11;
  endfunction
  // Inputs always move 2 ns after the edge
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  // Tolerance allows for one PWM sample of jitter
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol,
                     input string m);
    checks++;
    if ($isunknown(got) || ((got > exp) ? got - exp : exp - got) > tol) begin
      n_errors++;
      $display("CHECK FAILED %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask
  // Strobe drops for a cycle so writes never touch in one step
  task automatic wr(input blepc_cfg_t v);
    wr_cfg_i = v;
    wr_i = 1'h1;
    tick();
    wr_i = 1'h0;
    tick();
  endtask
  task automatic wait_act(input logic lvl, input int lim);
    for (k = 0; k < lim && active_o !== lvl; k++) tick();
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    tick(20);
    rst_n_i = 1'h1;
    tick(4);
    // Defaults, and a write while the pin is low
    chk(cfg_o, BLEPC_CFG_RST, 0, "defaults");
    chk(map_exp_o, 0, 0, "linear");
    c = BLEPC_CFG_RST;
    c.brt = 11'h155;
    wr(c);
    chk(cfg_o, BLEPC_CFG_RST, 0, "write while off");
    chk(enabled_o, 0, 0, "off");
    $display("test off done");
    // Stand-alone start with the PWM pin held high
    hi = 16'h0001;
    hardware_enable_pin_i = 1'h1;
    tick(8);
    chk(enabled_o, 1, 0, "enabled");
    wait_act(1'h1, 21000);
    chk(k, 20000, 40, "turn-on time");
    chk(led_code_o, 11'h7FF, 0, "full code");
    chk(sink_en_o, 3'h7, 0, "all sinks");
    $display("test stand-alone done");
    // Quarter duty, every brightness source mode
    per = 16'd200;
    hi = 16'd50;
    tick(1000);
    for (int m = 0; m < 4; m++) begin
      lf = lfsr(lf);
      c = BLEPC_CFG_RST;
      c.mode = 2'(m);
      c.brt = lf[10:0] | 11'h400;
      c.str_en = (lf[13:11] == 3'h0) ? 3'h5 : lf[13:11];
      wr(c);
      tick(10);
      chk(cfg_o, c, 0, "stored");
      chk(sink_en_o, c.str_en, 0, "sinks");
      chk(led_code_o, model(c, 511), (m == 0) ? 0 : 12, "code");
    end
    $display("test modes done");
    // No string, zero code, then the lowest code
    for (int j = 0; j < 3; j++) begin
      c = BLEPC_CFG_RST;
      c.mode = BLEPC_MODE_I2C;
      c.brt = (j == 0) ? 11'h2AA : 11'(j - 1);
      c.str_en = (j == 0) ? 3'h0 : 3'h7;
      wr(c);
      tick(5);
      chk(active_o, j == 2, 0, "on state");
      chk(led_code_o, (j == 2) ? 1 : 0, 0, "code");
      chk(sink_en_o, (j == 2) ? 7 : 0, 0, "sinks");
    end
    $display("test standby done");
    // Short pulses under the widest filter look static low
    c = BLEPC_CFG_RST;
    c.filt = 2'h3;
    wr(c);
    // Two-cycle pulses every 100 cycles, narrower than the filter
    per = 16'd100;
    hi = 16'h0002;
    wait_act(1'h0, 21000);
    chk(active_o, 0, 0, "glitch off");
    chk(pwm_timeout_o, 1, 0, "timeout");
    $display("test filter done");
    // Pin low brings the defaults back
    per = 16'h0000;
    hi = 16'h0000;
    hardware_enable_pin_i = 1'h0;
    tick(8);
    chk(cfg_o, BLEPC_CFG_RST, 0, "reset by pin");
    chk(enabled_o, 0, 0, "disabled");
    $display("test pin drop done");
    final_report();
  end
endmodule
